// File: logic/output_step_sequencer.sv
// step sequencer state machine for a programmable output source
`timescale 1ns/10ps
`include "step_seq_consts.svh"
module output_step_sequencer
  import step_seq_pkg::*;
#(
  parameter int TICK_CYCLES = `STEP_TICK_CYCLES
)(
  input  wire logic                    clk_i,                       // system clock
  input  wire logic                    sys_rst_i,                   // sync reset, high
  input  wire logic                    start_i,                     // start command pulse
  input  wire logic                    hold_i,                      // hold command pulse
  input  wire logic                    stop_i,                      // stop command pulse
  input  wire logic                    branch_i,                    // branch command pulse
  input  wire logic                    phase_zero_i,                // ac phase at 0 deg
  input  wire logic                    arbitrary_waveform_select_i, // arb waves in use
  input  wire logic                    prog_we_i,                   // step table write
  input  wire logic [`STEP_NUM_W-1:0]  prog_addr_i,                 // 0 = regular step
  input  wire step_param_type          prog_step_i,                 // step contents
  output seq_status_type               status_o,                    // idle, run, hold
  output logic [`STEP_NUM_W-1:0]       step_no_o,                   // executing step
  output out_param_type                out_o,                       // output parameters
  output logic [`SYNC_W-1:0]           sync_o                       // step sync code
);

  if (TICK_CYCLES < 2 || TICK_CYCLES > 65535)
  begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  step_param_type                steps_q [1:255];
  logic [`JUMP_CNT_W-1:0]        jcnt_q  [1:255];
  out_param_type                 reg_q;
  out_param_type                 out_q;
  seq_state_type                 state_q;
  seq_state_type                 state_d;
  logic [`STEP_NUM_W-1:0]        step_q;
  logic [`SYNC_W-1:0]            sync_q;
  logic [`STEP_TIME_W-1:0]       remain_q;
  logic [15:0]                   presc_q;
  logic                          held_term_q;
  logic                          resume_wait_q;
  logic                          arb_mode_q;
  logic [`WAVE_W-1:0]            fixed_wave_q;
  step_param_type                cur;
  logic                          tick;
  logic                          time_done;
  logic                          load_en;
  logic [`STEP_NUM_W-1:0]        load_idx;
  logic                          go_idle;
  logic                          term_hold;
  logic                          cnt_clr_all;
  logic                          cnt_inc;
  logic                          cnt_clr;
  logic [`STEP_NUM_W-1:0]        succ_idx;
  logic                          succ_inc;
  logic                          succ_clr;
  logic                          arb_now;
  logic [`WAVE_W-1:0]            wave_now;

  // next step number in order, without loop handling
  function automatic logic [`STEP_NUM_W-1:0] next_num(input logic [`STEP_NUM_W-1:0] n);
    next_num = n + `STEP_NUM_W'(1);
  endfunction : next_num

  // a step's output values with the waveform policy applied
  function automatic out_param_type step_out(input step_param_type s, input logic arbitrary_waveform_select,
                                             input logic [`WAVE_W-1:0] fixed);
    step_out      = s.outp;
    step_out.wave = arbitrary_waveform_select ? s.outp.wave : fixed;
  endfunction : step_out

  assign cur       = steps_q[(step_q == `STEP_NONE) ? `STEP_FIRST : step_q];
  assign tick      = (state_q == ST_RUN) && (presc_q == TICK_LAST);
  assign time_done = tick && (remain_q <= `STEP_TIME_W'(1));
  assign arb_now   = (state_q == ST_IDLE) ? arbitrary_waveform_select_i : arb_mode_q;
  assign wave_now  = (state_q == ST_IDLE) ? out_q.wave : fixed_wave_q;

  // loop decision for the current step
  always_comb
  begin
    succ_inc = 1'b0;
    succ_clr = 1'b0;
    succ_idx = next_num(step_q);
    if (cur.jump_to != `STEP_NONE)
    begin
      if (cur.jump_cnt == `JUMP_FOREVER)
      begin
        succ_idx = cur.jump_to;
      end
      else if (jcnt_q[step_q] < cur.jump_cnt)
      begin
        succ_idx = cur.jump_to;
        succ_inc = 1'b1;
      end
      else
      begin
        succ_clr = 1'b1;
      end
    end
  end

  // status transitions
  always_comb
  begin
    state_d     = state_q;
    load_en     = 1'b0;
    load_idx    = step_q;
    go_idle     = 1'b0;
    term_hold   = 1'b0;
    cnt_clr_all = 1'b0;
    cnt_inc     = 1'b0;
    cnt_clr     = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        if (start_i)
        begin
          state_d     = ST_RUN;
          load_en     = 1'b1;
          load_idx    = `STEP_FIRST;
          cnt_clr_all = 1'b1;
        end
      end
      ST_RUN, ST_WAIT:
      begin
        if (stop_i)
        begin
          state_d = ST_IDLE;
          go_idle = 1'b1;
        end
        else if (hold_i)
        begin
          state_d = ST_HOLD;
        end
        else if (branch_i && cur.branch_to != `STEP_NONE)
        begin
          state_d  = ST_RUN;
          load_en  = 1'b1;
          load_idx = cur.branch_to;
        end
        else if (state_q == ST_RUN && time_done && cur.phase_end_en)
        begin
          state_d = ST_WAIT;
        end
        else if ((state_q == ST_RUN && time_done && !cur.phase_end_en)
                 || (state_q == ST_WAIT && phase_zero_i))
        begin
          case (cur.term)
            hold_action:
            begin
              state_d   = ST_HOLD;
              term_hold = 1'b1;
            end
            idle_action:
            begin
              state_d = ST_IDLE;
              go_idle = 1'b1;
            end
            default:
            begin
              cnt_inc = succ_inc;
              cnt_clr = succ_clr;
              if (succ_idx == `STEP_NONE)
              begin
                state_d = ST_IDLE;
                go_idle = 1'b1;
              end
              else
              begin
                state_d  = ST_RUN;
                load_en  = 1'b1;
                load_idx = succ_idx;
              end
            end
          endcase
        end
      end
      ST_HOLD:
      begin
        if (stop_i)
        begin
          state_d = ST_IDLE;
          go_idle = 1'b1;
        end
        else if (start_i && held_term_q)
        begin
          cnt_inc = succ_inc;
          cnt_clr = succ_clr;
          if (succ_idx == `STEP_NONE)
          begin
            state_d = ST_IDLE;
            go_idle = 1'b1;
          end
          else
          begin
            state_d  = ST_RUN;
            load_en  = 1'b1;
            load_idx = succ_idx;
          end
        end
        else if (start_i)
        begin
          state_d = resume_wait_q ? ST_WAIT : ST_RUN;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // hold origin and resume point
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      held_term_q   <= 1'b0;
      resume_wait_q <= 1'b0;
    end
    else if (term_hold)
    begin
      held_term_q   <= 1'b1;
      resume_wait_q <= 1'b0;
    end
    else if (state_q != ST_HOLD && state_d == ST_HOLD)
    begin
      held_term_q   <= 1'b0;
      resume_wait_q <= (state_q == ST_WAIT);
    end
  end

  // step table
  always_ff @(posedge clk_i)
  begin
    if (prog_we_i && prog_addr_i != `STEP_NONE)
    begin
      steps_q[prog_addr_i] <= prog_step_i;
    end
  end

  // per-step jump counters
  for (genvar g = 1; g < 256; g++)
  begin : g_jcnt
    always_ff @(posedge clk_i)
    begin
      if (sys_rst_i || cnt_clr_all)
      begin
        jcnt_q[g] <= '0;
      end
      else if (cnt_clr && step_q == `STEP_NUM_W'(g))
      begin
        jcnt_q[g] <= '0;
      end
      else if (cnt_inc && step_q == `STEP_NUM_W'(g))
      begin
        jcnt_q[g] <= jcnt_q[g] + `JUMP_CNT_W'(1);
      end
    end
  end

  // waveform policy latched at sequence start
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      arb_mode_q   <= 1'b0;
      fixed_wave_q <= '0;
    end
    else if (state_q == ST_IDLE && start_i)
    begin
      arb_mode_q   <= arbitrary_waveform_select_i;
      fixed_wave_q <= out_q.wave;
    end
  end

  // regular-output step
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      reg_q <= '0;
    end
    else if (go_idle)
    begin
      reg_q <= out_q;
    end
    else if (prog_we_i && prog_addr_i == `STEP_NONE)
    begin
      reg_q <= prog_step_i.outp;
    end
  end

  // step timing; frozen outside run
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || load_en)
    begin
      presc_q  <= '0;
      remain_q <= load_en ? steps_q[load_idx].time_ticks : '0;
    end
    else if (state_q == ST_RUN)
    begin
      presc_q <= tick ? 16'h0000 : presc_q + 16'h0001;
      if (tick && remain_q != '0)
      begin
        remain_q <= remain_q - `STEP_TIME_W'(1);
      end
    end
  end

  // output parameters, step number and sync code
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      out_q  <= '0;
      step_q <= `STEP_NONE;
      sync_q <= `SYNC_FALSE;
    end
    else if (load_en)
    begin
      out_q  <= step_out(steps_q[load_idx], arb_now, wave_now);
      step_q <= load_idx;
      sync_q <= steps_q[load_idx].sync;
    end
    else if (go_idle || (state_q == ST_IDLE && state_d == ST_IDLE))
    begin
      out_q  <= go_idle ? out_q : reg_q;
      step_q <= `STEP_NONE;
      sync_q <= `SYNC_FALSE;
    end
    // run, wait and hold keep the step settings unchanged
  end

  assign status_o  = (state_q == ST_IDLE) ? SEQ_IDLE :
                     (state_q == ST_HOLD) ? SEQ_HOLD : SEQ_RUN;
  assign step_no_o = step_q;
  assign out_o     = out_q;
  assign sync_o    = sync_q;

  sequence s_start_idle;
    state_q == ST_IDLE && start_i;
  endsequence

  sequence s_hold_cmd;
    (state_q == ST_RUN || state_q == ST_WAIT) && !stop_i && hold_i;
  endsequence

  AST_START_STEP1: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_start_idle |=> state_q == ST_RUN && step_q == `STEP_FIRST)
    else $error("start from idle did not load step 1");

  AST_HOLD_FREEZE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q == ST_HOLD && state_d == ST_HOLD |=> $stable(out_q) && $stable(remain_q))
    else $error("outputs moved during hold");

  AST_HOLD_ENTER: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_hold_cmd |=> state_q == ST_HOLD ##0 $stable(step_q))
    else $error("hold command not taken");

  AST_RESUME: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q == ST_HOLD && !stop_i && start_i && !held_term_q
    |=> state_q != ST_HOLD && $stable(step_q) && $stable(remain_q) && $stable(presc_q))
    else $error("resume after hold lost the step");

  AST_STOP_IDLE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q != ST_IDLE && stop_i |=> state_q == ST_IDLE && reg_q == $past(out_q)
    && sync_q == `SYNC_FALSE)
    else $error("stop did not keep outputs in regular step");

  AST_BRANCH: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_q == ST_RUN || state_q == ST_WAIT) && !stop_i && !hold_i && branch_i
    && cur.branch_to != `STEP_NONE |=> step_q == $past(cur.branch_to))
    else $error("branch went to wrong step");

  AST_IDLE_SYNC: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q == ST_IDLE ##1 state_q == ST_IDLE |-> sync_o == `SYNC_FALSE)
    else $error("sync not false in regular output");

  AST_PHASE_WAIT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q == ST_WAIT && !phase_zero_i && !stop_i && !hold_i && !branch_i
    |=> state_q == ST_WAIT && $stable(out_q) && $stable(step_q))
    else $error("step ended before phase zero");

  AST_JUMP_LIMIT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    step_q != `STEP_NONE && cur.jump_cnt != `JUMP_FOREVER |-> jcnt_q[step_q] <= cur.jump_cnt)
    else $error("jump counter exceeded jump count");

  AST_TERM_HOLD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    term_hold |=> state_q == ST_HOLD && held_term_q)
    else $error("hold termination not taken");

endmodule : output_step_sequencer

// File: logic/step_seq_consts.svh
// constants and behaviour summary for the output step sequencer
// Behaviour
// - Sequencer has exactly three statuses: idle, run and hold.
// - Hold freezes every output parameter at its value when hold took effect.
// - Start from idle enters run and loads step 1 in the same cycle.
// - Start after a commanded hold resumes exactly, keeping remaining step time.
// - Start after a termination hold moves to that step's jump target.
// - Hold command switches a running sequencer into hold; idle ignores it.
// - Stop enters idle at once; regular step keeps the outputs present then.
// - Branch in run moves to the current step's branch target from the present output.
// - Every step has its own jump counter, allowing nested loops.
// - Jump count N jumps N times, so the loop body runs N plus one times.
// - Sync output shows the running step's code, false during regular output.
// - With end-phase enabled, step ends at first phase zero after step time.
// - While waiting for phase zero, outputs stay at the step's setting values.
// - Per-step waveform change only when arbitrary waveforms are in use.
// - Sine or square waveform stays fixed for the whole sequence.
// - Step termination action also changes status when the step ends.
// - Termination is continue, hold or idle; non-continue beats the jump target.
// - Jump target 1 to 255; zero means the next step number.
// - Jump count 1 to 999; zero means jump forever.
// - Step sync code is two bits wide.
`ifndef STEP_SEQ_CONSTS_SVH
`define STEP_SEQ_CONSTS_SVH
`define CLK_PERIOD_NS     25
`define STEP_TICK_NS      100000
`define STEP_TICK_CYCLES  ((`STEP_TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STEP_NUM_W        8
`define STEP_FIRST        8'h01
`define STEP_NONE         8'h00
`define JUMP_CNT_W        10
`define JUMP_CNT_MAX      999
`define JUMP_FOREVER      10'h000
`define STEP_TIME_W       24
`define SYNC_W            2
`define SYNC_FALSE        2'h0
`define DC_W              16
`define AC_W              16
`define FREQ_W            20
`define WAVE_W            4
`endif

// File: logic/step_seq_pkg.sv
// types of the output step sequencer
`include "step_seq_consts.svh"
package step_seq_pkg;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_RUN  = 2'h1,
    SEQ_HOLD = 2'h2
  } seq_status_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN  = 2'h1,
    ST_WAIT = 2'h3,
    ST_HOLD = 2'h2
  } seq_state_type;

  typedef enum logic [1:0] {
    continue_sequence_action = 2'h0,
    hold_action              = 2'h1,
    idle_action              = 2'h2
  } term_action_type;

  typedef struct packed {
    logic [`DC_W-1:0]   dc;
    logic [`AC_W-1:0]   ac;
    logic [`FREQ_W-1:0] freq;
    logic [`WAVE_W-1:0] wave;
  } out_param_type;

  typedef struct packed {
    out_param_type            outp;
    logic [`SYNC_W-1:0]       sync;
    logic [`STEP_TIME_W-1:0]  time_ticks;
    logic                     phase_end_en;
    term_action_type          term;
    logic [`STEP_NUM_W-1:0]   jump_to;
    logic [`JUMP_CNT_W-1:0]   jump_cnt;
    logic [`STEP_NUM_W-1:0]   branch_to;
  } step_param_type;
endpackage : step_seq_pkg

// File: bench/cmd_panel_model.sv
// command and ac phase source model facing the sequencer
`timescale 1ns/10ps
module cmd_panel_model (
  input  wire logic clk_i,    // system clock
  output logic      start_o,  // start pulse
  output logic      hold_o,   // hold pulse
  output logic      stop_o,   // stop pulse
  output logic      branch_o, // branch pulse
  output logic      phase_o   // ac phase at 0 deg
);
  initial
  begin
    {start_o, hold_o, stop_o, branch_o, phase_o} = 5'h00;
  end

  // one-cycle command, launched and dropped off falling edges
  task automatic issue(input logic [2:0] kind);
    @(negedge clk_i);
    start_o  = (kind == 3'h1);
    hold_o   = (kind == 3'h2);
    stop_o   = (kind == 3'h3);
    branch_o = (kind == 3'h4);
    @(negedge clk_i);
    {start_o, hold_o, stop_o, branch_o} = 4'h0;
  endtask : issue

  // single-cycle zero crossing of the superimposed ac
  task automatic phase_zero();
    @(negedge clk_i);
    phase_o = 1'b1;
    @(negedge clk_i);
    phase_o = 1'b0;
  endtask : phase_zero
endmodule : cmd_panel_model

// File: bench/output_step_sequencer_test.sv
// self-checking bench for the output step sequencer
`timescale 1ns/10ps
`include "step_seq_consts.svh"
module output_step_sequencer_test
  import step_seq_pkg::*;
;
  localparam logic [2:0]  GO = 3'h1;
  localparam logic [2:0]  HLD = 3'h2;
  localparam logic [2:0]  STP = 3'h3;
  localparam logic [2:0]  BRN = 3'h4;
  localparam logic [23:0] LONG = 24'h0003e8;
  typedef struct packed {
    logic [2:0]     cmd;
    seq_status_type st;
    logic [7:0]     sn;
    logic [7:0]     oi;
  } row_type;
  row_type                rows [12];
  step_param_type         steps [16];
  logic                   clk, sys_rst, arb_sel, we, start, hold, stop, branch, phase;
  logic [`STEP_NUM_W-1:0] addr, step_no, prev_no;
  step_param_type         pstep;
  seq_status_type         status;
  out_param_type          outp;
  logic [`SYNC_W-1:0]     sync;
  logic [`WAVE_W-1:0]     fixed;
  logic                   wave_bad;
  int                     mismatches, cmp_count, run1, entries, base, n;

  output_step_sequencer #(.TICK_CYCLES(4)) uut (
    .clk_i(clk), .sys_rst_i(sys_rst), .start_i(start), .hold_i(hold),
    .stop_i(stop), .branch_i(branch), .phase_zero_i(phase),
    .arbitrary_waveform_select_i(arb_sel), .prog_we_i(we), .prog_addr_i(addr),
    .prog_step_i(pstep), .status_o(status), .step_no_o(step_no), .out_o(outp),
    .sync_o(sync));
  cmd_panel_model panel (
    .clk_i(clk), .start_o(start), .hold_o(hold), .stop_o(stop),
    .branch_o(branch), .phase_o(phase));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // run time of step 1, loop entries into step 1, wave drift while running
  always @(negedge clk)
  begin
    if (status === SEQ_RUN && step_no === 8'h01) run1++;
    if (step_no === 8'h01 && prev_no !== 8'h01) entries++;
    if (status === SEQ_RUN && outp.wave !== fixed) wave_bad = 1'b1;
    prev_no = step_no;
  end

  task automatic note(input logic bad, input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (bad)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : note
  task automatic chk_status(input seq_status_type g, input seq_status_type e);
    note(g !== e, 64'(g), 64'(e));
  endtask : chk_status
  task automatic chk_num(input logic [15:0] g, input logic [15:0] e);
    note(g !== e, 64'(g), 64'(e));
  endtask : chk_num
  task automatic chk_out(input out_param_type g, input out_param_type e);
    note(g !== e, 64'(g), 64'(e));
  endtask : chk_out
  task automatic chk_sync(input logic [1:0] g, input logic [1:0] e);
    note(g !== e, 64'(g), 64'(e));
  endtask : chk_sync

  function automatic step_param_type mk(input logic [7:0] i, input logic [1:0] sy,
      input logic [23:0] t, input logic ph, input term_action_type tm,
      input logic [7:0] j, input logic [9:0] c, input logic [7:0] b);
    mk = '{'{16'h1000 + 16'(i), 16'h2000 + 16'(i), 20'h30000 + 20'(i), 4'(i)},
           sy, t, ph, tm, j, c, b};
  endfunction : mk

  task automatic prog(input logic [7:0] a, input step_param_type s);
    @(negedge clk);
    we = 1'b1;
    addr = a;
    pstep = s;
    steps[a] = s;
    @(negedge clk);
    we = 1'b0;
  endtask : prog

  task automatic wait_left(input logic [7:0] s);
    n = 0;
    while (step_no === s && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 5000) mismatches++;
  endtask : wait_left

  task automatic wait_status(input seq_status_type s);
    n = 0;
    while (status !== s && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 5000) mismatches++;
  endtask : wait_status

  task automatic expect_state(input seq_status_type st, input logic [7:0] sn,
      input logic [7:0] oi);
    chk_status(status, st);
    chk_num(16'(step_no), 16'(sn));
    chk_out(outp, steps[oi].outp);
    chk_sync(sync, (st == SEQ_IDLE) ? `SYNC_FALSE : steps[sn].sync);
  endtask : expect_state

  task automatic test_done();
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done();
  end

  initial
  begin
    sys_rst = 1'b1;
    arb_sel = 1'b1;
    we = 1'b0;
    addr = 8'h00;
    pstep = '0;
    {mismatches, cmp_count, run1, entries} = '0;
    fixed = 4'h0;
    wave_bad = 1'b0;
    prev_no = 8'h00;
    rows = '{'{GO, SEQ_RUN, 8'h01, 8'h01}, '{HLD, SEQ_HOLD, 8'h01, 8'h01},
             '{HLD, SEQ_HOLD, 8'h01, 8'h01}, '{GO, SEQ_RUN, 8'h01, 8'h01},
             '{BRN, SEQ_RUN, 8'h03, 8'h03}, '{GO, SEQ_RUN, 8'h03, 8'h03},
             '{BRN, SEQ_RUN, 8'h03, 8'h03}, '{STP, SEQ_IDLE, 8'h00, 8'h03},
             '{BRN, SEQ_IDLE, 8'h00, 8'h03}, '{HLD, SEQ_IDLE, 8'h00, 8'h03},
             '{GO, SEQ_RUN, 8'h01, 8'h01}, '{STP, SEQ_IDLE, 8'h00, 8'h01}};
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    chk_status(status, SEQ_IDLE);
    chk_num(16'(step_no), 16'h0000);
    chk_sync(sync, `SYNC_FALSE);
    chk_out(outp, '0);
    @(negedge clk);
    chk_out(outp, '0);
    // regular-output step written at address zero shows in idle
    prog(0, mk(9, 2'h0, 24'h000001, 1'b0, continue_sequence_action, 0, 0, 0));
    @(negedge clk);
    chk_out(outp, steps[0].outp);
    chk_sync(sync, `SYNC_FALSE);
    prog(1, mk(1, 2'h1, LONG, 1'b0, continue_sequence_action, 0, 0, 3));
    prog(2, mk(2, 2'h2, LONG, 1'b0, continue_sequence_action, 0, 0, 0));
    prog(3, mk(3, 2'h3, LONG, 1'b0, continue_sequence_action, 0, 0, 0));
    foreach (rows[k])
    begin
      panel.issue(rows[k].cmd);
      @(negedge clk);
      expect_state(rows[k].st, rows[k].sn, rows[k].oi);
    end
    // pause mid-step must not lose or gain step time
    prog(1, mk(1, 2'h1, 24'h000004, 1'b0, continue_sequence_action, 0, 0, 3));
    run1 = 0;
    panel.issue(GO);
    @(negedge clk);
    wait_left(8'h01);
    base = run1;
    note(!(base == 16 || base == 17), 64'(base), 64'h10);
    panel.issue(STP);
    run1 = 0;
    panel.issue(GO);
    repeat (5) @(negedge clk);
    panel.issue(HLD);
    @(negedge clk);
    expect_state(SEQ_HOLD, 8'h01, 8'h01);
    repeat (30) @(negedge clk);
    expect_state(SEQ_HOLD, 8'h01, 8'h01);
    panel.issue(GO);
    @(negedge clk);
    wait_left(8'h01);
    chk_num(16'(run1), 16'(base));
    panel.issue(STP);
    // termination hold beats the jump target, start then takes the target
    prog(2, mk(2, 2'h2, 24'h000001, 1'b0, hold_action, 8'h07, 0, 0));
    prog(7, mk(7, 2'h3, LONG, 1'b0, continue_sequence_action, 0, 0, 0));
    panel.issue(GO);
    @(negedge clk);
    wait_status(SEQ_HOLD);
    expect_state(SEQ_HOLD, 8'h02, 8'h02);
    panel.issue(GO);
    @(negedge clk);
    expect_state(SEQ_RUN, 8'h07, 8'h07);
    panel.issue(STP);
    // step end waits for the ac zero crossing
    prog(1, mk(1, 2'h1, 24'h000001, 1'b1, continue_sequence_action, 0, 0, 0));
    panel.issue(GO);
    repeat (40) @(negedge clk);
    expect_state(SEQ_RUN, 8'h01, 8'h01);
    panel.phase_zero();
    repeat (2) @(negedge clk);
    chk_num(16'(step_no), 16'h0002);
    panel.issue(STP);
    // nested loops with a fixed sine or square wave
    arb_sel = 1'b0;
    prog(1, mk(1, 2'h1, 24'h000001, 1'b0, continue_sequence_action, 0, 0, 0));
    prog(2, mk(2, 2'h2, 24'h000001, 1'b0, continue_sequence_action, 1, 10'h002, 0));
    prog(3, mk(3, 2'h3, 24'h000001, 1'b0, continue_sequence_action, 1, 10'h001, 0));
    prog(4, mk(4, 2'h1, 24'h000001, 1'b0, idle_action, 0, 0, 0));
    fixed = outp.wave;
    wave_bad = 1'b0;
    entries = 0;
    panel.issue(GO);
    @(negedge clk);
    wait_status(SEQ_IDLE);
    chk_num(16'(entries), 16'h0006);
    chk_num(16'(wave_bad), 16'h0000);
    chk_num(16'(step_no), 16'h0000);
    chk_sync(sync, `SYNC_FALSE);
    // second reset in mid-run
    arb_sel = 1'b1;
    panel.issue(GO);
    repeat (3) @(negedge clk);
    sys_rst = 1'b1;
    @(negedge clk);
    sys_rst = 1'b0;
    chk_status(status, SEQ_IDLE);
    chk_num(16'(step_no), 16'h0000);
    chk_sync(sync, `SYNC_FALSE);
    chk_out(outp, '0);
    @(negedge clk);
    chk_status(status, SEQ_IDLE);
    chk_out(outp, '0);
    test_done();
  end
endmodule : output_step_sequencer_test
